// >>> hw/dspwm_pkg.sv
/*
  Package of the dual six-plus-two pulse width modulator: register
  indices, field positions, reset values, divider codes and counts.
  Assumes one system clock; the divider source clock is CLK itself.
*/
package dspwm_pkg;

  // ------------------------------------------------------------------
  // register map: index, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [3:0] DSPWM_IDX_CTRL0 = 4'h0;
  localparam logic [3:0] DSPWM_IDX_DUTY0 = 4'h1;
  localparam logic [3:0] DSPWM_IDX_CTRL1 = 4'h2;
  localparam logic [3:0] DSPWM_IDX_DUTY1 = 4'h3;

  // ------------------------------------------------------------------
  // control field layout and reset values
  // ------------------------------------------------------------------
  localparam int         DSPWM_RUN_HI   = 7;
  localparam int         DSPWM_RUN_LO   = 6;
  localparam int         DSPWM_DIV_HI   = 2;
  localparam int         DSPWM_DIV_LO   = 0;
  localparam logic [1:0] DSPWM_RUN_RST  = 2'h0;
  localparam logic [2:0] DSPWM_DIV_RST  = 3'h0;
  localparam logic [7:0] DSPWM_DUTY_RST = 8'h00;

  // ------------------------------------------------------------------
  // counts
  // ------------------------------------------------------------------
  localparam int         DSPWM_SUB_LEN  = 64;   // counter clocks per sub-cycle
  localparam int         DSPWM_FULL_LEN = 256;  // counter clocks per full cycle
  localparam int         DSPWM_PRE_W    = 7;    // widest divide is 128

  typedef enum logic [1:0] {
    DSPWM_HOLD_LOW  = 2'b00,
    DSPWM_HOLD_HIGH = 2'b01,
    DSPWM_RUN_A     = 2'b10,
    DSPWM_RUN_B     = 2'b11
  } dspwm_run_t;

  // terminal count of the prescaler for a divider code
  function automatic logic [DSPWM_PRE_W-1:0] dspwm_div_last(input logic [2:0] code);
    logic [DSPWM_PRE_W-1:0] r;
    r = 7'h01;
    case (code)
      3'h0, 3'h1: r = 7'h01;
      3'h2:       r = 7'h03;
      3'h3:       r = 7'h07;
      3'h4:       r = 7'h0f;
      3'h5:       r = 7'h1f;
      3'h6:       r = 7'h3f;
      default:    r = 7'h7f;
    endcase
    return r;
  endfunction : dspwm_div_last

endpackage : dspwm_pkg

// >>> hw/dspwm_cfg_if.sv
/*
  Interface carrying one channel's settings from the register file to
  a channel engine. Assumes a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface dspwm_cfg_if;
  logic [1:0] run_select_field;
  logic [2:0] clock_divider_select;
  logic [7:0] duty_value;
  modport regs (output run_select_field, output clock_divider_select, output duty_value);
  modport chan (input run_select_field, input clock_divider_select, input duty_value);
endinterface : dspwm_cfg_if
`default_nettype wire

// >>> hw/dspwm_chan.sv
/*
  One modulator channel: prescaler, 8-bit cycle counter and output.
  Assumes its settings are stable registers in the CLK domain.
*/
`timescale 1ns/10ps
`default_nettype none
module dspwm_chan
  import dspwm_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     resetn,
  dspwm_cfg_if.chan     cfg,
  output logic          pulse_output
);

  // ------------------------------------------------------------------
  // prescaler and cycle counter
  // ------------------------------------------------------------------
  logic [DSPWM_PRE_W-1:0] pre_q, pre_d;
  logic [7:0]             cnt_q, cnt_d;
  logic                   out_q, out_d;
  logic                   tick;
  logic                   run;
  logic [5:0]             coarse_duty;
  logic [1:0]             fine_extra_count;
  logic [6:0]             high_len;

  assign run              = cfg.run_select_field[1];
  assign coarse_duty      = cfg.duty_value[7:2];
  assign fine_extra_count = cfg.duty_value[1:0];
  assign tick             = (pre_q >= dspwm_div_last(cfg.clock_divider_select));

  // sub-cycle index from the next count, the one the output compares, so the
  // first clock of each sub-cycle uses its own length and not the previous one
  always_comb begin
    high_len = {1'b0, coarse_duty};
    if (cnt_d[7:6] < fine_extra_count) begin
      high_len = 7'({1'b0, coarse_duty} + 7'h01);
    end
  end

  // counter held at zero while stopped so runs start near a boundary
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (!run) begin
      pre_d = '0;
      cnt_d = '0;
    end else if (tick) begin
      pre_d = '0;
      cnt_d = 8'(cnt_q + 8'h01);                          // wraps at 256
    end else begin
      pre_d = 7'(pre_q + 7'h01);
    end
  end

  // duty read live each clock so a write lands in the running cycle
  always_comb begin
    case (cfg.run_select_field)
      DSPWM_HOLD_LOW:  out_d = 1'b0;
      DSPWM_HOLD_HIGH: out_d = 1'b1;
      default:         out_d = ({1'b0, cnt_d[5:0]} < high_len);
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign pulse_output = out_q;

endmodule : dspwm_chan
`default_nettype wire

// >>> hw/dspwm_top.sv
/*
  Top of the dual six-plus-two modulator: register file on a plain
  strobe port and two channel engines. Assumes a master that never
  raises both strobes together; read data stand one cycle later.
*/
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dspwm_top
  import dspwm_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic      [1:0] PULSE_OUTPUT
);

  // ------------------------------------------------------------------
  // registers, two channels side by side
  // ------------------------------------------------------------------
  logic [1:0] run_q [2];
  logic [1:0] run_d [2];
  logic [2:0] div_q [2];
  logic [2:0] div_d [2];
  logic [7:0] duty_q [2];
  logic [7:0] duty_d [2];
  logic [7:0] rdata_q, rdata_d;

  function automatic logic [7:0] ctrl_view(input logic [1:0] r, input logic [2:0] d);
    return {r, 3'h0, d};
  endfunction : ctrl_view

  // write decode; unmapped addresses are ignored, bits 5..3 dropped
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      run_d[c]  = run_q[c];
      div_d[c]  = div_q[c];
      duty_d[c] = duty_q[c];
    end
    if (WR) begin
      case (ADDR)
        DSPWM_IDX_CTRL0: begin
          run_d[0] = WDATA[DSPWM_RUN_HI:DSPWM_RUN_LO];
          div_d[0] = WDATA[DSPWM_DIV_HI:DSPWM_DIV_LO];
        end
        DSPWM_IDX_CTRL1: begin
          run_d[1] = WDATA[DSPWM_RUN_HI:DSPWM_RUN_LO];
          div_d[1] = WDATA[DSPWM_DIV_HI:DSPWM_DIV_LO];
        end
        DSPWM_IDX_DUTY0: duty_d[0] = WDATA;
        DSPWM_IDX_DUTY1: duty_d[1] = WDATA;
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        DSPWM_IDX_CTRL0: rdata_d = ctrl_view(run_q[0], div_q[0]);
        DSPWM_IDX_CTRL1: rdata_d = ctrl_view(run_q[1], div_q[1]);
        DSPWM_IDX_DUTY0: rdata_d = duty_q[0];
        DSPWM_IDX_DUTY1: rdata_d = duty_q[1];
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int c = 0; c < 2; c++) begin
        run_q[c]  <= DSPWM_RUN_RST;
        div_q[c]  <= DSPWM_DIV_RST;
        duty_q[c] <= DSPWM_DUTY_RST;
      end
      rdata_q <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        run_q[c]  <= run_d[c];
        div_q[c]  <= div_d[c];
        duty_q[c] <= duty_d[c];
      end
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // ------------------------------------------------------------------
  // channel engines
  // ------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chan
    dspwm_cfg_if cfg ();
    assign cfg.run_select_field     = run_q[g];
    assign cfg.clock_divider_select = div_q[g];
    assign cfg.duty_value           = duty_q[g];
    dspwm_chan u_chan (
      .clk          (CLK),
      .resetn       (RESETN),
      .cfg          (cfg),
      .pulse_output (PULSE_OUTPUT[g])
    );
  end

endmodule : dspwm_top
`default_nettype wire

// >>> testbench/dspwm_properties.sv
/*
  Port checker of the dual modulator top, bound to dspwm_top.
  Assumes the plain strobe bus and one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dspwm_properties (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [1:0] PULSE_OUTPUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (RD && ADDR > 4'h3 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  ctrl_gap_a: assert property (RD && (ADDR == 4'h0 || ADDR == 4'h2) |=> RDATA[5:3] == 3'h0)
    else $error("unbuilt control bits read back");
  ctrl_echo_a: assert property (WR && (ADDR == 4'h0 || ADDR == 4'h2)
    ##1 RD && ADDR == $past(ADDR)
    |=> RDATA == {$past(WDATA[7:6], 2), 3'h0, $past(WDATA[2:0], 2)})
    else $error("control readback wrong");
  duty_echo_a: assert property (WR && (ADDR == 4'h1 || ADDR == 4'h3)
    ##1 RD && ADDR == $past(ADDR)
    |=> RDATA == $past(WDATA, 2)) else $error("duty readback wrong");
  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  reset_out_a: assert property ($rose(RESETN) |-> PULSE_OUTPUT == 2'h0 && RDATA == 8'h00)
    else $error("outputs not clear after reset");
  hold_low_a: assert property (WR && ADDR == 4'h0 && WDATA[7:6] == 2'h0
    |-> ##2 !PULSE_OUTPUT[0]) else $error("held low output not low");
  hold_high_a: assert property (WR && ADDR == 4'h2 && WDATA[7:6] == 2'h1
    |-> ##2 PULSE_OUTPUT[1]) else $error("held high output not high");
endmodule : dspwm_properties
bind dspwm_top dspwm_properties u_props (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PULSE_OUTPUT(PULSE_OUTPUT));
`default_nettype wire

// >>> testbench/dspwm_load.sv
/*
  Buzzer-like load on one pulse output: counts high clocks and rises.
  Assumes clr is a one-cycle pulse from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module dspwm_load (
  input  wire logic clk,
  input  wire logic clr,
  input  wire logic drive,
  output var  int   hi_cnt,
  output var  int   rise_cnt
);
  logic prev_q;
  // rises give the modulation rate, high clocks the average duty
  always_ff @(posedge clk) begin
    prev_q   <= drive;
    hi_cnt   <= clr ? 0 : hi_cnt + int'(drive);
    rise_cnt <= clr ? 0 : rise_cnt + int'(drive && !prev_q);
  end
endmodule : dspwm_load
`default_nettype wire

// >>> testbench/tb.sv
/*
  Self-checking bench of dspwm_top with two loads.
  Assumes one 250 MHz clock and the index-based strobe port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic CLK = 0, RESETN = 0, WR = 0, RD = 0, clr = 0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA, s = 8'h23;
  logic [1:0] PULSE_OUTPUT;
  int mismatches = 0, checks_done = 0, hi0, rs0, hi1, rs1, n;
  logic [7:0] q[$];
  dspwm_top u_dspwm_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PULSE_OUTPUT(PULSE_OUTPUT));
  dspwm_load u_ld0 (.clk(CLK), .clr(clr), .drive(PULSE_OUTPUT[0]), .hi_cnt(hi0), .rise_cnt(rs0));
  dspwm_load u_ld1 (.clk(CLK), .clr(clr), .drive(PULSE_OUTPUT[1]), .hi_cnt(hi1), .rise_cnt(rs1));
  always #2 CLK = ~CLK;
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // read data are looked at in the single cycle they stand
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b0;
    #1 chk(RDATA === e, "read data");
  endtask : rd
  // fixed window: counters clear, then exactly w clocks are counted
  task automatic win(input int w);
    @(posedge CLK) clr <= 1'b1;
    @(posedge CLK) clr <= 1'b0;
    repeat (w) @(posedge CLK);
    #1;
  endtask : win
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
    acc(1'b1, 4'h0, 8'hff);
    rd(4'h0, 8'hc7);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h40);
    repeat (2) @(posedge CLK);
    #1 chk(PULSE_OUTPUT === 2'b10, "hold levels");
    // duty values are written while running, measured after one full cycle
    wr(4'h0, 8'h80);
    q = '{8'h03, 8'hff};
    repeat (3) begin
      s = lfsr(s);
      q.push_back(s);
    end
    foreach (q[i]) begin
      acc(1'b1, 4'h1, q[i]);
      rd(4'h1, q[i]);
      repeat (512) @(posedge CLK);
      win(512);
      chk(hi0 == 2 * int'(q[i]), "full cycle duty");
    end
    // every divider code: two modulation rises in 128 counter clocks
    wr(4'h3, 8'h85);
    for (int c = 0; c < 8; c++) begin
      n = (c < 2) ? 2 : (1 << c);
      wr(4'h2, {2'b11, 3'b000, 3'(c)});
      repeat (64 * n) @(posedge CLK);
      win(128 * n);
      chk(rs1 == 2, "modulation rate");
    end
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge CLK);
    mismatches++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
